/* File: core/bradc_pkg.sv */
// package of constants for the bridge converter readout block
package bradc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int MOD_RATE_HZ      = 76800;
  localparam int MOD_DIV          = (CLK_MHZ * 1000000) / MOD_RATE_HZ;
  localparam int MOD_DIV_W        = 11;
  localparam int DEC_SLOW         = 7680;          // modulator samples per result at 10 SPS
  localparam int DEC_FAST         = 960;           // modulator samples per result at 80 SPS
  localparam int DEC_W            = 13;
  localparam int STANDBY_US       = 20;
  localparam int STANDBY_CYC      = STANDBY_US * CLK_MHZ;
  localparam int STANDBY_W        = 12;
  // ---------------------------------------------------------------
  // data format
  // ---------------------------------------------------------------
  localparam int RES_W            = 18;
  localparam int ACC_W            = 56;
  localparam int BITCNT_W         = 5;
  localparam int MAX_SCLK         = 24;
  localparam logic [17:0] POS_FS  = 18'h1FFFF;
  localparam logic [17:0] NEG_FS  = 18'h20000;
endpackage

/* File: core/bradc_readout.sv */
// digital side of the bridge converter: rate, power-down, sinc4 filter, serial readout
`timescale 1ns/10ps
// Summary of operation
// - converts continuously, 10 SPS with rate select low, 80 SPS high
// - power-down low resets all conversion logic except result_r, which keeps its last value
// - each of the first 18 shift-clock rising edges presents the next result bit
// - shift clock held high also requests standby
// - line driven low means a new result is ready
// - first rising edge after ready switches line to data, msb first
// - results are 18 bits wide
// - sinc4 decimation of modulator bits at 76.8 kHz
// - clocks beyond 18 bits force line high until next result
// - two's complement result, clipped to 1FFFFh and 20000h
// - standby after shift clock high 20 us; low wakes the device
module bradc_readout #(
  parameter int DEC_SLOW_P = bradc_pkg::DEC_SLOW,
  parameter int DEC_FAST_P = bradc_pkg::DEC_FAST
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // pin controls
  input  wire logic power_down_n_i,
  input  wire logic speed_i,
  // modulator bitstream from the analog side
  input  wire logic mod_bit_i,
  // serial link
  input  wire logic sclk_i,
  output logic      ready_data_out_o,
  // status
  output logic      standby_o,
  output logic      mod_strobe_o
);
  // widths from the package keep filter and result in step
  localparam int W  = bradc_pkg::ACC_W;
  localparam int RW = bradc_pkg::RES_W;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclk_sy_r;
  logic [1:0] pdn_sy_r;
  logic [1:0] spd_sy_r;
  logic [1:0] mod_sy_r;
  logic       sclk_d_r;
  logic       run;
  logic       sclk_rise;

  // two stages each; logic reads only the second stage of each pair,
  // so a pin change reaches the logic two to three clocks late
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_sy_r <= 2'h0;
      pdn_sy_r  <= 2'h0;
      spd_sy_r  <= 2'h0;
      mod_sy_r  <= 2'h0;
      sclk_d_r  <= 1'b0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[0], sclk_i};
      pdn_sy_r  <= {pdn_sy_r[0], power_down_n_i};
      spd_sy_r  <= {spd_sy_r[0], speed_i};
      mod_sy_r  <= {mod_sy_r[0], mod_bit_i};
      sclk_d_r  <= sclk_sy_r[1];
    end
  end

  assign run       = pdn_sy_r[1];
  assign sclk_rise = sclk_sy_r[1] & ~sclk_d_r;

  // ---------------------------------------------------------------
  // standby detection
  // ---------------------------------------------------------------
  logic [bradc_pkg::STANDBY_W-1:0] hi_cnt_r;
  logic                            stby_hit;

  // count holds at its end value, so this stays true for the whole standby;
  // readout and strobe use it to act in the same cycle that standby_o rises
  assign stby_hit = run & sclk_sy_r[1]
                  & (hi_cnt_r == bradc_pkg::STANDBY_W'(bradc_pkg::STANDBY_CYC - 1));

  // clock held high for the activation time enters standby; low wakes
  // any high stretch counts, not only one that follows a ready indication
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt_r  <= '0;
      standby_o <= 1'b0;
    end else if (!run || !sclk_sy_r[1]) begin
      hi_cnt_r  <= '0;
      standby_o <= 1'b0;
    end else if (hi_cnt_r == bradc_pkg::STANDBY_W'(bradc_pkg::STANDBY_CYC - 1)) begin
      standby_o <= 1'b1;
    end else begin
      hi_cnt_r  <= hi_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // modulator sample strobe, 76.8 kHz
  // ---------------------------------------------------------------
  logic [bradc_pkg::MOD_DIV_W-1:0] div_r;
  logic                            tick;
  assign tick = (div_r == bradc_pkg::MOD_DIV_W'(bradc_pkg::MOD_DIV - 1));

  // free divider; the oscillator keeps running in standby
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r        <= '0;
      mod_strobe_o <= 1'b0;
    end else begin
      div_r        <= (!run || tick) ? '0 : div_r + 1'b1;
      // the analog side sleeps in standby, so no sample strobe goes out
      mod_strobe_o <= run & tick & ~stby_hit;
    end
  end

  // ---------------------------------------------------------------
  // sinc4 filter: four integrators, four combs at decimation
  // ---------------------------------------------------------------
  logic [W-1:0]                   integ_r [4];
  logic [W-1:0]                   comb_d_r [4];
  logic [W-1:0]                   comb_v [5];
  logic [bradc_pkg::DEC_W-1:0]    dec_cnt_r;
  logic [bradc_pkg::DEC_W-1:0]    dec_len;
  logic                           dec_done;
  logic                           conv_en;
  logic                           new_res_r;
  logic [RW-1:0]                  result_r;
  logic signed [W-1:0]            scaled;

  assign conv_en  = run & ~standby_o & tick;
  assign dec_len  = spd_sy_r[1] ? bradc_pkg::DEC_W'(DEC_FAST_P)
                                : bradc_pkg::DEC_W'(DEC_SLOW_P);
  // greater-or-equal so a switch to the fast rate mid-conversion ends it at
  // once instead of letting the counter run round its full range
  assign dec_done = conv_en & (dec_cnt_r >= dec_len - 1'b1);

  // integrators run at the modulator rate; wraparound is harmless in CIC
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) integ_r[i] <= '0;
      dec_cnt_r <= '0;
    end else if (!run || standby_o) begin
      for (int i = 0; i < 4; i++) integ_r[i] <= '0;
      dec_cnt_r <= '0;
    end else if (conv_en) begin
      integ_r[0] <= integ_r[0] + (mod_sy_r[1] ? W'(1) : {W{1'b1}});
      for (int i = 1; i < 4; i++) integ_r[i] <= integ_r[i] + integ_r[i-1];
      dec_cnt_r <= dec_done ? '0 : dec_cnt_r + 1'b1;
    end
  end

  // comb chain evaluated combinationally at the decimation instant
  always_comb begin
    comb_v[0] = integ_r[3];
    for (int i = 0; i < 4; i++) comb_v[i+1] = comb_v[i] - comb_d_r[i];
  end

  // gain of dec_len^4 normalised by shifting; slow path divides further
  // with shortened decimation the shift leaves little more than the sign
  assign scaled = spd_sy_r[1] ? ($signed(comb_v[4]) >>> 22) : ($signed(comb_v[4]) >>> 34);

  // delays of the comb stages and clipped result capture
  // results in progress are dropped in standby; the first one after wake comes from an emptied filter and is partial
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) comb_d_r[i] <= '0;
      result_r  <= '0;
      new_res_r <= 1'b0;
    end else if (!run || standby_o) begin
      for (int i = 0; i < 4; i++) comb_d_r[i] <= '0;
      new_res_r <= 1'b0;
    end else begin
      new_res_r <= dec_done;
      if (dec_done) begin
        for (int i = 0; i < 4; i++) comb_d_r[i] <= comb_v[i];
        if (scaled > $signed(W'(bradc_pkg::POS_FS)))
          result_r <= bradc_pkg::POS_FS;
        else if (scaled < -$signed(W'(bradc_pkg::NEG_FS)))
          result_r <= bradc_pkg::NEG_FS;
        else
          result_r <= scaled[RW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // serial readout
  // ---------------------------------------------------------------
  // bit_cnt_r stops at the clock limit, so later rises change nothing
  logic [RW-1:0]                    shift_r;
  logic [bradc_pkg::BITCNT_W-1:0]   bit_cnt_r;

  // line idles high; a new result pulls it low, rising edges shift out
  // a result landing mid-readback overwrites the shifter; the host keeps pace
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_r          <= '0;
      bit_cnt_r        <= '0;
      ready_data_out_o <= 1'b1;
    end else if (!run) begin
      shift_r          <= '0;
      bit_cnt_r        <= '0;
      ready_data_out_o <= 1'b1;
    end else if (stby_hit) begin
      // standby holds the line high and abandons any readback in progress
      bit_cnt_r        <= bradc_pkg::BITCNT_W'(bradc_pkg::MAX_SCLK);
      ready_data_out_o <= 1'b1;
    end else if (new_res_r) begin
      shift_r          <= result_r;
      bit_cnt_r        <= '0;
      ready_data_out_o <= 1'b0;
    end else if (sclk_rise && bit_cnt_r != bradc_pkg::BITCNT_W'(bradc_pkg::MAX_SCLK)) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      if (bit_cnt_r < bradc_pkg::BITCNT_W'(RW)) begin
        ready_data_out_o <= shift_r[RW-1];
        shift_r          <= {shift_r[RW-2:0], 1'b0};
      end else begin
        ready_data_out_o <= 1'b1;
      end
    end
  end
endmodule

/* File: test/bradc_readout_sva.sv */
// assertion checker for the bridge converter readout ports
`timescale 1ns/10ps
module bradc_readout_sva (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // watched ports
  input  wire logic power_down_n_i,
  input  wire logic sclk_i,
  input  wire logic ready_data_out_o,
  input  wire logic standby_o,
  input  wire logic mod_strobe_o
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_strobe_pulse:
    assert property (mod_strobe_o |=> !mod_strobe_o [*8]) else $error("strobe too long");
  a_pd_line_idle:
    assert property (!power_down_n_i [*4] |-> ready_data_out_o && !standby_o)
    else $error("power-down left state");
  a_pd_no_strobe:
    assert property (!power_down_n_i [*4] |-> !mod_strobe_o) else $error("strobe in power-down");
  a_wake_clear:
    assert property (!sclk_i [*5] |-> !standby_o) else $error("standby with sclk low");
  a_standby_entry:
    assert property ($rose(standby_o) |-> $past(sclk_i, 8) && $past(sclk_i, 4))
    else $error("standby without sclk high");
  a_standby_line:
    assert property (standby_o |-> ready_data_out_o) else $error("line low in standby");
  a_standby_quiet:
    assert property (standby_o |-> !mod_strobe_o) else $error("strobe in standby");
  a_sync_delay:
    assert property (!ready_data_out_o && $rose(sclk_i) |=> $stable(ready_data_out_o) [*2])
    else $error("line moved before sync");
endmodule

bind bradc_readout bradc_readout_sva chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .power_down_n_i(power_down_n_i), .sclk_i(sclk_i),
  .ready_data_out_o(ready_data_out_o), .standby_o(standby_o), .mod_strobe_o(mod_strobe_o)
);

/* File: test/bradc_host_model.sv */
// host model: polls the ready line and clocks results out
`timescale 1ns/10ps
module bradc_host_model (
  // serial link
  output logic      sclk_o,
  input  wire logic line_i
);
  initial sclk_o = 1'b0;
  // drive sclk level; high for long enough requests standby
  task automatic set_sclk(input logic v);
    sclk_o = v;
  endtask
  // wait for ready, read at once so no result is overwritten, then flush to 24 clocks
  task automatic read_word(output logic [17:0] d, output logic tail);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 30000) begin
      #10 n++;
    end
    // no ready in time: unknowns make the compares on this word count as mismatches
    if (n >= 30000) begin
      d    = 'x;
      tail = 1'bx;
      return;
    end
    for (int i = 0; i < 24; i++) begin
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
      if (i < 18) d[17 - i] = line_i; // sampled at the fall, 40 ns before next rise
    end
    tail = line_i;
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the bridge converter readout block
`timescale 1ns/10ps
module testbench;
  // short decimation keeps the run small
  localparam int SLOW = 4;
  localparam int FAST = 2;
  logic        clk_i = 1'b0, nrst_i = 1'b0, pd_n = 1'b1, speed = 1'b0, mbit = 1'b1;
  wire logic   sclk, line, stby, strobe;
  int          fails = 0, total_checks = 0, p;
  logic [17:0] d;
  logic        tail;
  time         t0;
  always #5 clk_i = ~clk_i;
  bradc_readout #(.DEC_SLOW_P(SLOW), .DEC_FAST_P(FAST)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .power_down_n_i(pd_n), .speed_i(speed),
    .mod_bit_i(mbit), .sclk_i(sclk), .ready_data_out_o(line), .standby_o(stby),
    .mod_strobe_o(strobe));
  bradc_host_model host (.sclk_o(sclk), .line_i(line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // result spacing per rate, first two results after the change discarded
  task automatic test_rate();
    for (int s = 0; s < 2; s++) begin
      speed = s[0];
      repeat (2) host.read_word(d, tail);
      t0 = $time;
      host.read_word(d, tail);
      p = int'(($time - t0) / 10) - (s ? FAST : SLOW) * bradc_pkg::MOD_DIV;
      check(p >= -3 && p <= 3, 1'b1);
    end
    $display("rate test done");
  endtask
  // full-scale inputs give the sign, four partial results dropped
  task automatic test_data();
    for (int b = 1; b >= 0; b--) begin
      mbit = b[0];
      repeat (5) host.read_word(d, tail);
      check(d[17], !b[0]);
      check(tail, 1'b1);
    end
    $display("data test done");
  endtask
  // sclk held high must wait out the activation time
  task automatic test_standby();
    host.set_sclk(1'b1);
    repeat (1900) @(negedge clk_i);
    check(stby, 1'b0);
    repeat (200) @(negedge clk_i);
    check(stby, 1'b1);
    check(line, 1'b1);
    host.set_sclk(1'b0);
    repeat (6) @(negedge clk_i);
    check(stby, 1'b0);
    $display("standby test done");
  endtask
  // power-down while a result waits clears the ready indication
  task automatic test_pd();
    for (int n = 0; n < 30000 && line !== 1'b0; n++) @(negedge clk_i);
    check(line, 1'b0);
    pd_n = 1'b0;
    repeat (5) @(negedge clk_i);
    check(line, 1'b1);
    check(strobe, 1'b0);
    pd_n = 1'b1;
    host.read_word(d, tail);
    check(tail, 1'b1);
    $display("power-down test done");
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    test_rate();
    test_data();
    test_standby();
    test_pd();
    complete_run();
  end
  // watchdog sized well above the expected run
  initial begin
    #1000000 fails++;
    complete_run();
  end
endmodule
